/* File: hdl/store_xfer_pkg.sv */
package store_xfer_pkg;

  // Opcodes handled by the decoder
  localparam logic [7:0] SET_IRQ_MASK_OP     = 8'h78;
  localparam logic [7:0] STORE_ACCUM_OP_ZP   = 8'h85;
  localparam logic [7:0] STORE_ACCUM_OP_ZPX  = 8'h95;
  localparam logic [7:0] STORE_ACCUM_OP_ABS  = 8'h8D;
  localparam logic [7:0] STORE_ACCUM_OP_ABSX = 8'h9D;
  localparam logic [7:0] STORE_ACCUM_OP_ABSY = 8'h99;
  localparam logic [7:0] STORE_ACCUM_OP_INDX = 8'h81;
  localparam logic [7:0] STORE_ACCUM_OP_INDY = 8'h91;
  localparam logic [7:0] STORE_XINDEX_OP_ZP  = 8'h86;
  localparam logic [7:0] STORE_XINDEX_OP_ZPY = 8'h96;
  localparam logic [7:0] STORE_XINDEX_OP_ABS = 8'h8E;
  localparam logic [7:0] MOVE_ACCUM_TO_XIDX  = 8'hAA;
  localparam logic [7:0] MOVE_ACCUM_TO_YIDX  = 8'hA8;
  localparam logic [7:0] MOVE_YIDX_TO_ACCUM  = 8'h98;
  localparam logic [7:0] MOVE_SP_TO_XIDX     = 8'hBA;
  localparam logic [7:0] MOVE_XIDX_TO_ACCUM  = 8'h8A;
  localparam logic [7:0] MOVE_XIDX_TO_SP     = 8'h9A;
  // Immediate loads, so that the data registers can be seeded
  localparam logic [7:0] LOAD_ACCUM_IMM      = 8'hA9;
  localparam logic [7:0] LOAD_XIDX_IMM       = 8'hA2;
  localparam logic [7:0] LOAD_YIDX_IMM       = 8'hA0;

  // Status byte bit positions
  localparam int FLAG_N = 7;
  localparam int FLAG_I = 2;
  localparam int FLAG_Z = 1;

  localparam logic [7:0]  ZP_PAGE = 8'h00;
  localparam logic [15:0] PC_RST  = 16'h0000;

  typedef enum logic [3:0] {
    ST_FETCH = 4'h0,
    ST_IMPL  = 4'h1,
    ST_OPND  = 4'h2,
    ST_ZPIDX = 4'h3,
    ST_HIGH  = 4'h4,
    ST_PTRLO = 4'h5,
    ST_PTRHI = 4'h6,
    ST_FIX   = 4'h7,
    ST_WRITE = 4'h8
  } state_t;

  typedef enum logic [2:0] {
    M_IMPL = 3'h0,
    M_IMM  = 3'h1,
    M_ZP   = 3'h2,
    M_ZPI  = 3'h3,
    M_ABS  = 3'h4,
    M_ABSI = 3'h5,
    M_INDX = 3'h6,
    M_INDY = 3'h7
  } mode_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        we;
  } mem_req_t;

  typedef struct packed {
    logic [7:0] a;
    logic [7:0] x;
    logic [7:0] y;
    logic [7:0] sp;
    logic [7:0] p;
  } cpu_regs_t;

  localparam cpu_regs_t REGS_RST = '{a: 8'h00, x: 8'h00, y: 8'h00, sp: 8'hFF, p: 8'h20};

  function automatic mode_t decode_mode(input logic [7:0] op);
    case (op)
      STORE_ACCUM_OP_ZP, STORE_XINDEX_OP_ZP:        decode_mode = M_ZP;
      STORE_ACCUM_OP_ZPX, STORE_XINDEX_OP_ZPY:      decode_mode = M_ZPI;
      STORE_ACCUM_OP_ABS, STORE_XINDEX_OP_ABS:      decode_mode = M_ABS;
      STORE_ACCUM_OP_ABSX, STORE_ACCUM_OP_ABSY:     decode_mode = M_ABSI;
      STORE_ACCUM_OP_INDX:                          decode_mode = M_INDX;
      STORE_ACCUM_OP_INDY:                          decode_mode = M_INDY;
      LOAD_ACCUM_IMM, LOAD_XIDX_IMM, LOAD_YIDX_IMM: decode_mode = M_IMM;
      default:                              decode_mode = M_IMPL;
    endcase
  endfunction

  function automatic logic [7:0] set_nz(input logic [7:0] p, input logic [7:0] v);
    logic [7:0] r;
    r         = p;
    r[FLAG_N] = v[7];
    r[FLAG_Z] = (v == 8'h00);
    set_nz    = r;
  endfunction

endpackage

/* File: hdl/cpu_store_transfer_decode.sv */
// Overview of operation
// - 78 sets interrupt mask, two cycles
// - 85 stores accumulator zero page, three cycles
// - 95 stores accumulator zero page plus X
// - 8D stores accumulator absolute, four cycles
// - 9D absolute plus X, always five cycles
// - 99 absolute plus Y, always five cycles
// - 81 indexed pointer then store, six cycles
// - 91 pointer plus Y store, six cycles
// - 86, 96, 8E store X, no flags
// - AA copies accumulator into X
// - A8 copies accumulator into Y
// - 98 copies Y into accumulator, sets NZ
// - BA copies stack pointer into X
// - 8A copies X into accumulator
// - 9A copies X into stack pointer
`timescale 1ns/10ps
module cpu_store_transfer_decode (
  // Clock and reset
  input  wire logic                 mclk,
  input  wire logic                 rst_n,
  // Memory bus
  input  wire logic [7:0]           rd_data,
  output store_xfer_pkg::mem_req_t  bus_ff,
  output logic                      sync_ff,
  // Programmer-visible registers
  output store_xfer_pkg::cpu_regs_t regs_ff
);
  import store_xfer_pkg::*;

  state_t    state_ff;
  state_t    nxt_state;
  logic [7:0]  opcode_ff;
  logic [7:0]  lo_ff;
  logic [7:0]  nxt_lo;
  logic [15:0] pc_ff;
  logic [15:0] nxt_pc;
  logic [15:0] ea_ff;
  logic [15:0] nxt_ea;
  mem_req_t  nxt_bus;
  cpu_regs_t nxt_regs;
  cpu_regs_t exec_regs;

  wire mode_t       cur_mode   = decode_mode(opcode_ff);
  wire mode_t       new_mode   = decode_mode(rd_data);
  wire logic [7:0]  nxt_opcode = (state_ff == ST_FETCH) ? rd_data : opcode_ff;
  wire logic        use_y      = (opcode_ff == STORE_XINDEX_OP_ZPY) ||
                                 (opcode_ff == STORE_ACCUM_OP_ABSY) ||
                                 (opcode_ff == STORE_ACCUM_OP_INDY);
  wire logic        xidx_store = (opcode_ff == STORE_XINDEX_OP_ZP) ||
                                 (opcode_ff == STORE_XINDEX_OP_ZPY) ||
                                 (opcode_ff == STORE_XINDEX_OP_ABS);
  wire logic [7:0]  idx        = use_y ? regs_ff.y : regs_ff.x;
  wire logic [7:0]  store_val  = xidx_store ? regs_ff.x : regs_ff.a;
  wire logic [15:0] pc_inc     = pc_ff + 16'h0001;
  // Eight-bit sum never carries into the page byte
  wire logic [7:0]  zp_sum     = rd_data + idx;
  wire logic [15:0] full_addr  = {rd_data, lo_ff};
  // Page fix-up is always spent, crossing or not
  wire logic [15:0] idx_addr   = full_addr + {8'h00, idx};
  wire logic [7:0]  lo_unfixed = lo_ff + idx;
  wire logic [15:0] ptr_next   = {ZP_PAGE, ea_ff[7:0] + 8'h01};

  // Register effects of implied and immediate instructions
  always_comb begin
    exec_regs = regs_ff;
    case (opcode_ff)
      SET_IRQ_MASK_OP: exec_regs.p[FLAG_I] = 1'b1;
      MOVE_ACCUM_TO_XIDX: begin
        exec_regs.x = regs_ff.a;
        exec_regs.p = set_nz(regs_ff.p, regs_ff.a);
      end
      MOVE_ACCUM_TO_YIDX: begin
        exec_regs.y = regs_ff.a;
        exec_regs.p = set_nz(regs_ff.p, regs_ff.a);
      end
      MOVE_YIDX_TO_ACCUM: begin
        exec_regs.a = regs_ff.y;
        exec_regs.p = set_nz(regs_ff.p, regs_ff.y);
      end
      MOVE_SP_TO_XIDX: begin
        exec_regs.x = regs_ff.sp;
        exec_regs.p = set_nz(regs_ff.p, regs_ff.sp);
      end
      MOVE_XIDX_TO_ACCUM: begin
        exec_regs.a = regs_ff.x;
        exec_regs.p = set_nz(regs_ff.p, regs_ff.x);
      end
      MOVE_XIDX_TO_SP: exec_regs.sp = regs_ff.x;
      LOAD_ACCUM_IMM: begin
        exec_regs.a = rd_data;
        exec_regs.p = set_nz(regs_ff.p, rd_data);
      end
      LOAD_XIDX_IMM: begin
        exec_regs.x = rd_data;
        exec_regs.p = set_nz(regs_ff.p, rd_data);
      end
      LOAD_YIDX_IMM: begin
        exec_regs.y = rd_data;
        exec_regs.p = set_nz(regs_ff.p, rd_data);
      end
      default: exec_regs = regs_ff;
    endcase
  end

  // Sequencer: each state is one bus cycle
  always_comb begin
    nxt_state = state_ff;
    nxt_pc    = pc_ff;
    nxt_ea    = ea_ff;
    nxt_lo    = lo_ff;
    nxt_regs  = regs_ff;
    nxt_bus   = '{addr: pc_ff, wdata: 8'h00, we: 1'b0};
    case (state_ff)
      ST_FETCH: begin
        nxt_pc       = pc_inc;
        nxt_bus.addr = pc_inc;
        nxt_state    = (new_mode == M_IMPL) ? ST_IMPL : ST_OPND;
      end
      ST_IMPL: begin
        nxt_regs  = exec_regs;
        nxt_state = ST_FETCH;
      end
      ST_OPND: begin
        nxt_pc = pc_inc;
        nxt_lo = rd_data;
        case (cur_mode)
          M_IMM: begin
            nxt_regs     = exec_regs;
            nxt_bus.addr = pc_inc;
            nxt_state    = ST_FETCH;
          end
          M_ZP: begin
            nxt_bus.addr = {ZP_PAGE, rd_data};
            nxt_state    = ST_WRITE;
          end
          M_ZPI, M_INDX: begin
            nxt_bus.addr = {ZP_PAGE, rd_data};
            nxt_ea       = {ZP_PAGE, zp_sum};
            nxt_state    = ST_ZPIDX;
          end
          M_INDY: begin
            nxt_bus.addr = {ZP_PAGE, rd_data};
            nxt_ea       = {ZP_PAGE, rd_data};
            nxt_state    = ST_PTRLO;
          end
          default: begin
            nxt_bus.addr = pc_inc;
            nxt_state    = ST_HIGH;
          end
        endcase
      end
      ST_ZPIDX: begin
        nxt_bus.addr = ea_ff;
        nxt_state    = (cur_mode == M_INDX) ? ST_PTRLO : ST_WRITE;
      end
      ST_PTRLO: begin
        nxt_lo       = rd_data;
        nxt_bus.addr = ptr_next;
        nxt_state    = ST_PTRHI;
      end
      ST_HIGH, ST_PTRHI: begin
        if (state_ff == ST_HIGH) begin
          nxt_pc = pc_inc;
        end
        if (cur_mode == M_ABS || cur_mode == M_INDX) begin
          nxt_bus.addr = full_addr;
          nxt_state    = ST_WRITE;
        end else begin
          nxt_bus.addr = {rd_data, lo_unfixed};
          nxt_ea       = idx_addr;
          nxt_state    = ST_FIX;
        end
      end
      ST_FIX: begin
        nxt_bus.addr = ea_ff;
        nxt_state    = ST_WRITE;
      end
      ST_WRITE: nxt_state = ST_FETCH;
      default:  nxt_state = ST_FETCH;
    endcase
    if (nxt_state == ST_WRITE) begin
      nxt_bus.we    = 1'b1;
      nxt_bus.wdata = store_val;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff  <= ST_FETCH;
      opcode_ff <= 8'h00;
      lo_ff     <= 8'h00;
      pc_ff     <= PC_RST;
      ea_ff     <= 16'h0000;
      bus_ff    <= '{addr: PC_RST, wdata: 8'h00, we: 1'b0};
      sync_ff   <= 1'b1;
      regs_ff   <= REGS_RST;
    end else begin
      state_ff  <= nxt_state;
      opcode_ff <= nxt_opcode;
      lo_ff     <= nxt_lo;
      pc_ff     <= nxt_pc;
      ea_ff     <= nxt_ea;
      bus_ff    <= nxt_bus;
      sync_ff   <= (nxt_state == ST_FETCH);
      regs_ff   <= nxt_regs;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence s_op(logic [7:0] op);
    sync_ff && rd_data == op;
  endsequence

  sequence s_write_end;
    bus_ff.we && bus_ff.wdata == regs_ff.a ##1 sync_ff && !bus_ff.we;
  endsequence

  property p_mask_set;
    s_op(SET_IRQ_MASK_OP) |-> ##2 (sync_ff && regs_ff.p[FLAG_I] &&
                                   regs_ff.a == $past(regs_ff.a, 2));
  endproperty
  a_mask_set: assert property (p_mask_set) else $error("mask set failed");

  property p_acc_zp;
    s_op(STORE_ACCUM_OP_ZP) |-> ##1 !bus_ff.we
                                ##1 bus_ff.addr[15:8] == ZP_PAGE ##0 s_write_end;
  endproperty
  a_acc_zp: assert property (p_acc_zp) else $error("zero page store wrong");

  property p_acc_zpx;
    s_op(STORE_ACCUM_OP_ZPX) |-> ##1 (!bus_ff.we)[*2]
                                 ##1 bus_ff.addr[15:8] == ZP_PAGE ##0 s_write_end;
  endproperty
  a_acc_zpx: assert property (p_acc_zpx) else $error("zp indexed store wrong");

  property p_acc_abs;
    s_op(STORE_ACCUM_OP_ABS) |-> ##1 (!bus_ff.we)[*2] ##1 s_write_end;
  endproperty
  a_acc_abs: assert property (p_acc_abs) else $error("absolute store wrong");

  property p_acc_absx;
    s_op(STORE_ACCUM_OP_ABSX) |-> ##1 (!bus_ff.we)[*3] ##1 s_write_end;
  endproperty
  a_acc_absx: assert property (p_acc_absx) else $error("abs X store wrong");

  property p_acc_absy;
    s_op(STORE_ACCUM_OP_ABSY) |-> ##1 (!bus_ff.we)[*3] ##1 s_write_end;
  endproperty
  a_acc_absy: assert property (p_acc_absy) else $error("abs Y store wrong");

  property p_acc_indx;
    s_op(STORE_ACCUM_OP_INDX) |-> ##1 (!bus_ff.we)[*4] ##1 s_write_end;
  endproperty
  a_acc_indx: assert property (p_acc_indx) else $error("indexed pointer store wrong");

  property p_acc_indy;
    s_op(STORE_ACCUM_OP_INDY) |-> ##1 (!bus_ff.we)[*4] ##1 s_write_end;
  endproperty
  a_acc_indy: assert property (p_acc_indy) else $error("pointer Y store wrong");

  property p_xidx_zp;
    s_op(STORE_XINDEX_OP_ZP) |-> ##2 (bus_ff.we && bus_ff.wdata == regs_ff.x)
                                 ##1 (sync_ff && $stable(regs_ff.p));
  endproperty
  a_xidx_zp: assert property (p_xidx_zp) else $error("X store wrong");

  property p_a_to_x;
    s_op(MOVE_ACCUM_TO_XIDX) |-> ##2 (regs_ff.x == $past(regs_ff.a, 2) &&
                                      regs_ff.p[FLAG_Z] == (regs_ff.x == 8'h00));
  endproperty
  a_a_to_x: assert property (p_a_to_x) else $error("A to X wrong");

  property p_a_to_y;
    s_op(MOVE_ACCUM_TO_YIDX) |-> ##2 (regs_ff.y == $past(regs_ff.a, 2) &&
                                      regs_ff.p[FLAG_N] == regs_ff.y[7]);
  endproperty
  a_a_to_y: assert property (p_a_to_y) else $error("A to Y wrong");

  property p_y_to_a;
    s_op(MOVE_YIDX_TO_ACCUM) |-> ##2 (regs_ff.a == $past(regs_ff.y, 2) &&
                                      regs_ff.p[FLAG_N] == regs_ff.a[7] &&
                                      regs_ff.p[FLAG_Z] == (regs_ff.a == 8'h00));
  endproperty
  a_y_to_a: assert property (p_y_to_a) else $error("Y to A wrong");

  property p_sp_to_x;
    s_op(MOVE_SP_TO_XIDX) |-> ##2 (regs_ff.x == $past(regs_ff.sp, 2) &&
                                   regs_ff.p[FLAG_N] == regs_ff.x[7]);
  endproperty
  a_sp_to_x: assert property (p_sp_to_x) else $error("SP to X wrong");

  property p_x_to_a;
    s_op(MOVE_XIDX_TO_ACCUM) |-> ##2 (regs_ff.a == $past(regs_ff.x, 2) &&
                                      regs_ff.p[FLAG_Z] == (regs_ff.a == 8'h00));
  endproperty
  a_x_to_a: assert property (p_x_to_a) else $error("X to A wrong");

  property p_x_to_sp;
    s_op(MOVE_XIDX_TO_SP) |-> ##2 (regs_ff.sp == $past(regs_ff.x, 2) &&
                                   regs_ff.p == $past(regs_ff.p, 2));
  endproperty
  a_x_to_sp: assert property (p_x_to_sp) else $error("X to SP wrong");

endmodule // cpu_store_transfer_decode

/* File: verif/mem_model.sv */
`timescale 1ns/10ps
module mem_model
  import store_xfer_pkg::*;
(
  // Clock
  input  wire logic                       mclk,
  // Processor bus
  input  wire store_xfer_pkg::mem_req_t   bus,
  output logic [7:0]                      rd_data
);
  logic [7:0] mem [0:65535];

  // Cleared store, so dummy reads never return unknowns
  initial begin
    for (int k = 0; k < 65536; k++) begin
      mem[k] = 8'h00;
    end
  end

  // Zero-wait memory: the byte for the shown address is presented mid-cycle
  always @(negedge mclk) begin
    rd_data <= mem[bus.addr];
  end

  always @(posedge mclk) begin
    if (bus.we === 1'b1) begin
      mem[bus.addr] <= bus.wdata;
    end
  end
endmodule // mem_model

/* File: verif/cpu_store_transfer_decode_test.sv */
`timescale 1ns/10ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin failures++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module cpu_store_transfer_decode_test;
  import store_xfer_pkg::*;
  typedef struct packed {
    logic [7:0]  op;
    logic [7:0]  b1;
    logic [7:0]  b2;
    logic [1:0]  len;
    logic [3:0]  cyc;
    logic        we;
    logic [15:0] wa;
    logic [7:0]  wd;
    cpu_regs_t   r;
  } row_t;
  logic        mclk;
  logic        rst_n;
  logic [7:0]  rd_data;
  mem_req_t    bus_ff;
  logic        sync_ff;
  cpu_regs_t   regs_ff;
  int          failures;
  int          comparisons;
  int          n;
  int          wr;
  logic [15:0] pc;
  // Opcode, operands, length, cycles, write, address, data, registers afterwards
  row_t rows [0:22] = '{
    {8'hA9, 8'h80, 8'h00, 2'h2, 4'h2, 1'b0, 16'h0000, 8'h00, 40'h800000FFA0},
    {8'hA2, 8'h05, 8'h00, 2'h2, 4'h2, 1'b0, 16'h0000, 8'h00, 40'h800500FF20},
    {8'hA0, 8'h10, 8'h00, 2'h2, 4'h2, 1'b0, 16'h0000, 8'h00, 40'h800510FF20},
    {8'h78, 8'h00, 8'h00, 2'h1, 4'h2, 1'b0, 16'h0000, 8'h00, 40'h800510FF24},
    {8'h85, 8'h40, 8'h00, 2'h2, 4'h3, 1'b1, 16'h0040, 8'h80, 40'h800510FF24},
    {8'h95, 8'hFE, 8'h00, 2'h2, 4'h4, 1'b1, 16'h0003, 8'h80, 40'h800510FF24},
    {8'h8D, 8'h34, 8'h12, 2'h3, 4'h4, 1'b1, 16'h1234, 8'h80, 40'h800510FF24},
    {8'h9D, 8'hFE, 8'h12, 2'h3, 4'h5, 1'b1, 16'h1303, 8'h80, 40'h800510FF24},
    {8'h99, 8'h00, 8'h20, 2'h3, 4'h5, 1'b1, 16'h2010, 8'h80, 40'h800510FF24},
    {8'h81, 8'hC0, 8'h00, 2'h2, 4'h6, 1'b1, 16'h3000, 8'h80, 40'h800510FF24},
    {8'h91, 8'hD0, 8'h00, 2'h2, 4'h6, 1'b1, 16'h3100, 8'h80, 40'h800510FF24},
    {8'h86, 8'hC2, 8'h00, 2'h2, 4'h3, 1'b1, 16'h00C2, 8'h05, 40'h800510FF24},
    {8'h96, 8'hFF, 8'h00, 2'h2, 4'h4, 1'b1, 16'h000F, 8'h05, 40'h800510FF24},
    {8'h8E, 8'h00, 8'h40, 2'h3, 4'h4, 1'b1, 16'h4000, 8'h05, 40'h800510FF24},
    {8'hAA, 8'h00, 8'h00, 2'h1, 4'h2, 1'b0, 16'h0000, 8'h00, 40'h808010FFA4},
    {8'hA8, 8'h00, 8'h00, 2'h1, 4'h2, 1'b0, 16'h0000, 8'h00, 40'h808080FFA4},
    {8'hA0, 8'h00, 8'h00, 2'h2, 4'h2, 1'b0, 16'h0000, 8'h00, 40'h808000FF26},
    {8'h98, 8'h00, 8'h00, 2'h1, 4'h2, 1'b0, 16'h0000, 8'h00, 40'h008000FF26},
    {8'hBA, 8'h00, 8'h00, 2'h1, 4'h2, 1'b0, 16'h0000, 8'h00, 40'h00FF00FFA4},
    {8'h8A, 8'h00, 8'h00, 2'h1, 4'h2, 1'b0, 16'h0000, 8'h00, 40'hFFFF00FFA4},
    {8'hA2, 8'h81, 8'h00, 2'h2, 4'h2, 1'b0, 16'h0000, 8'h00, 40'hFF8100FFA4},
    {8'hA9, 8'h00, 8'h00, 2'h2, 4'h2, 1'b0, 16'h0000, 8'h00, 40'h008100FF26},
    {8'h9A, 8'h00, 8'h00, 2'h1, 4'h2, 1'b0, 16'h0000, 8'h00, 40'h0081008126}
  };

  cpu_store_transfer_decode cpu_store_transfer_decode_i (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .rd_data (rd_data),
    .bus_ff  (bus_ff),
    .sync_ff (sync_ff),
    .regs_ff (regs_ff)
  );

  mem_model mem_model_i (
    .mclk    (mclk),
    .bus     (bus_ff),
    .rd_data (rd_data)
  );

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic finish_test;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Follows one instruction from its fetch to the next fetch
  task automatic run_row(input row_t rw);
    `CHK(bus_ff.addr, pc)
    n = 0;
    wr = 0;
    do begin
      @(negedge mclk);
      n++;
      if (bus_ff.we === 1'b1) begin
        wr++;
        `CHK(bus_ff.addr, rw.wa)
        `CHK(bus_ff.wdata, rw.wd)
      end
    end while (sync_ff !== 1'b1 && n < 12);
    if (n >= 12) begin
      failures++;
      finish_test();
    end
    `CHK(n, int'(rw.cyc))
    `CHK(wr, int'(rw.we))
    `CHK(regs_ff, rw.r)
    pc = pc + 16'(rw.len);
  endtask

  initial begin
    repeat (3000) @(posedge mclk);
    failures++;
    finish_test();
  end

  initial begin
    rst_n = 1'b0;
    failures = 0;
    comparisons = 0;
    pc = 16'h0000;
    #1;
    foreach (rows[i]) begin
      mem_model_i.mem[pc] = rows[i].op;
      mem_model_i.mem[pc + 16'h0001] = rows[i].b1;
      if (rows[i].len == 2'h3) begin
        mem_model_i.mem[pc + 16'h0002] = rows[i].b2;
      end
      pc = pc + 16'(rows[i].len);
    end
    // Pointers for the indirect stores
    mem_model_i.mem[16'h00C5] = 8'h00;
    mem_model_i.mem[16'h00C6] = 8'h30;
    mem_model_i.mem[16'h00D0] = 8'hF0;
    mem_model_i.mem[16'h00D1] = 8'h30;
    pc = 16'h0000;
    repeat (12) @(negedge mclk);
    `CHK(bus_ff, mem_req_t'(25'h0))
    `CHK(sync_ff, 1'b1)
    `CHK(regs_ff, REGS_RST)
    rst_n = 1'b1;
    foreach (rows[i]) begin
      run_row(rows[i]);
    end
    // Reset in mid-run, off the clock edge
    #2 rst_n = 1'b0;
    #1;
    `CHK(regs_ff, REGS_RST)
    `CHK(bus_ff, mem_req_t'(25'h0))
    `CHK(sync_ff, 1'b1)
    @(negedge mclk);
    rst_n = 1'b1;
    pc = 16'h0000;
    run_row(rows[0]);
    finish_test();
  end
endmodule // cpu_store_transfer_decode_test
